/* File: tbfbi_pkg.sv */
// Purpose: Shared constants, types and register map of the terminal bus fault blink indicator
// Assumes: 50 MHz ref_clk, 32-bit AHB-Lite register access, one word per register
// Notes:   Times are kept in their own unit; cycle counts derive from them and the clock rate
package tbfbi_pkg;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int unsigned CLK_KHZ       = 50_000;
    localparam int unsigned FAST_HALF_MS  = 50;    // Lead-in blink half period
    localparam int unsigned SLOW_HALF_MS  = 250;   // Code and argument pulse half period
    localparam int unsigned PAUSE_MS      = 1000;  // Dark pause between code and argument
    localparam int unsigned GAP_MS        = 2000;  // Dark gap before the sequence repeats
    localparam int unsigned UPDATE_MS     = 2;     // Terminal bus update period
    localparam int unsigned BUS_RESET_MS  = 1;     // Length of the acyclic bus reset
    localparam int unsigned FAST_HALF_CYC = FAST_HALF_MS * CLK_KHZ;
    localparam int unsigned SLOW_HALF_CYC = SLOW_HALF_MS * CLK_KHZ;
    localparam int unsigned PAUSE_CYC     = PAUSE_MS * CLK_KHZ;
    localparam int unsigned GAP_CYC       = GAP_MS * CLK_KHZ;
    localparam int unsigned UPDATE_CYC    = UPDATE_MS * CLK_KHZ;
    localparam int unsigned BUS_RESET_CYC = BUS_RESET_MS * CLK_KHZ;
    localparam logic [5:0]  LEAD_BLINKS   = 6'h08;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Register map (byte offsets) and reset values
    localparam logic [7:0]  OFS_STATUS  = 8'h00;
    localparam logic [7:0]  OFS_CTRL    = 8'h04;
    localparam logic [7:0]  OFS_FAULT   = 8'h08;
    localparam logic [7:0]  OFS_ACTMAP  = 8'h0C;
    localparam logic [31:0] ACTMAP_RST  = 32'hFFFF_FFFF;

    // Status word bits
    localparam int ST_BUS_ERR  = 0;
    localparam int ST_CFG_CHG  = 1;
    localparam int ST_LEN_ERR  = 2;
    localparam int ST_NO_INPUT = 8;
    localparam int ST_IN_BUSY  = 9;
    localparam int ST_OUT_BUSY = 10;
    localparam int ST_WDOG     = 11;
    localparam int ST_ACYCLIC  = 15;

    // Control and fault register fields
    localparam int CTRL_RESET_CALL = 0;
    localparam int CTRL_USER_LAMP  = 1;
    localparam int FLT_CODE_LSB    = 8;
    localparam int FLT_PERSIST     = 30;
    localparam int FLT_ACTIVE      = 31;

    // Fault codes
    localparam logic [3:0] CODE_BREAK   = 4'h4;
    localparam logic [3:0] CODE_REGCOMM = 4'h5;
    localparam logic [3:0] CODE_LENGTH  = 4'h7;

    // Lamp colours as red, green, blue
    localparam logic [2:0] RGB_RED    = 3'h4;
    localparam logic [2:0] RGB_GREEN  = 3'h2;
    localparam logic [2:0] RGB_BLUE   = 3'h1;
    localparam logic [2:0] RGB_YELLOW = 3'h6;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {RT_RUN, RT_STOP, RT_CONFIG, RT_FAULT} tbfbi_rt_mode_t;

    typedef enum logic [3:0] {
        BL_IDLE, BL_LEAD_ON, BL_LEAD_OFF, BL_CODE_ON, BL_CODE_OFF,
        BL_PAUSE, BL_ARG_ON, BL_ARG_OFF, BL_GAP
    } tbfbi_blink_t;

    // Condition inputs from the runtime and the terminal bus engine
    typedef struct packed {
        tbfbi_rt_mode_t rtMode;
        logic           bootDone;
        logic           bootFault;
        logic           fieldbusRun;
        logic           busBreak;      // Pulse: data error from a break
        logic [5:0]     breakSlot;     // Physical slot the break sits behind, 0 = supply
        logic           regFail;       // Pulse: register communication failed
        logic [5:0]     regSlot;       // Physical slot (1-based) of the failing module
        logic           lenMismatch;   // Pulse: process data lengths differ
        logic           cfgChanged;    // Pulse: terminal configuration changed
        logic           inputsValid;
        logic           inBusy;
        logic           outBusy;
        logic           watchdog;      // Pulse: watchdog event
    } tbfbi_evt_t;

    typedef struct packed {
        logic [2:0] runtime_status_lamp;
        logic       sysFault;
        logic       busRun;
        logic       busErr;
        logic       user_diag_lamp;
    } tbfbi_lamps_t;

endpackage

/* File: tbfbi_indicator.sv */
// Purpose: Status lamps, coded fault blinking and diagnostic status word of the terminal bus
// Assumes: Condition inputs synchronous to ref_clk; event inputs are one-cycle pulses
// Notes:   Times scale by parameters
// Function
// [R1] Runtime lamp colour follows runtime mode
// [R2] System fault lamp red until clean start-up
// [R3] Bus run lamp only when fault-free, fieldbus running
// [R4] Fault lamp dark without error, flashes with error
// [R5] Fault flashes use fast and slow rates
// [R6] Lead-in, code pulses, pause, argument pulses
// [R7] Argument is position of last preceding module
// [R8] Passive modules skipped in position count
// [R9] Bus break gives code 4, position argument
// [R10] Register communication failure gives code 5
// [R11] Length mismatch gives code 7, argument 0
// [R12] Some faults persist until power cycle
// [R13] Status word zero only when synchronous, error-free
// [R14] Nonzero may mean busy, not only fault
// [R15] Host task period below 100 ms
// [R16] Bus update every one to five ms
// [R17] Bits 0,1,2: error, config change, length
// [R18] Bits 8,9: no inputs, input update busy
// [R19] Bit 10: output update busy
// [R20] Bits 11,15: watchdog, acyclic function active
// [R21] Reset call clears errors via acyclic reset
// [R22] Flash sequence repeats, starting with lead-in
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/1ps
module tbfbi_indicator
    import tbfbi_pkg::*;
#(
    parameter int unsigned FAST_HALF_CYC = tbfbi_pkg::FAST_HALF_CYC,
    parameter int unsigned SLOW_HALF_CYC = tbfbi_pkg::SLOW_HALF_CYC,
    parameter int unsigned PAUSE_CYC     = tbfbi_pkg::PAUSE_CYC,
    parameter int unsigned GAP_CYC       = tbfbi_pkg::GAP_CYC,
    parameter int unsigned UPDATE_CYC    = tbfbi_pkg::UPDATE_CYC,
    parameter int unsigned BUS_RESET_CYC = tbfbi_pkg::BUS_RESET_CYC
) (
    input  wire logic                  ref_clk,
    input  wire logic                  srst,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire tbfbi_pkg::tbfbi_evt_t evt,
    output tbfbi_pkg::tbfbi_lamps_t    lamps,
    output logic                       busUpdate,
    output logic                       busResetActive
);
    import tbfbi_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////////
    // State of the whole block
    typedef struct packed {
        logic         ahbWrite;
        logic [7:0]   ahbAddr;
        logic [31:0]  rdata;
        logic         ready;
        logic         userLamp;
        logic [31:0]  actMap;
        logic         cfgChg;
        logic         wdog;
        logic         lenErr;
        logic         faultAct;
        logic         faultPersist;
        logic [3:0]   faultCode;
        logic [5:0]   faultArg;
        logic         rstActive;
        logic [31:0]  rstTimer;
        logic [31:0]  updTimer;
        logic         updStrobe;
        tbfbi_blink_t blink;
        logic [31:0]  blinkTimer;
        logic [5:0]   pulseCnt;
        logic [3:0]   showCode;
        logic [5:0]   showArg;
        tbfbi_lamps_t lamps;
    } tbfbi_state_t;

    tbfbi_state_t st;
    tbfbi_state_t next_st;
    logic         doReset;
    logic [15:0]  statusWord;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Active modules in slots below the given physical slot; passive ones are skipped
    function automatic logic [5:0] countActive(input logic [31:0] map, input logic [5:0] slot);
        logic [5:0] cnt;
        cnt = 6'h00;
        for (int i = 0; i < 32; i++) begin
            if ((6'(i) < slot) && map[i]) begin  // [R8]
                cnt = cnt + 6'h01;
            end
        end
        return cnt;  // [R7]
    endfunction

    // Half periods as timer loads
    function automatic logic [31:0] load(input int unsigned cyc);
        return (cyc > 1) ? 32'(cyc - 1) : 32'h0000_0000;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Diagnostic status word; busy bits make it nonzero even without a fault
    always_comb begin
        statusWord              = 16'h0000;
        statusWord[ST_BUS_ERR]  = st.faultAct; // [R17] [R13]
        statusWord[ST_CFG_CHG]  = st.cfgChg; // [R17]
        statusWord[ST_LEN_ERR]  = st.lenErr; // [R17]
        statusWord[ST_NO_INPUT] = ~evt.inputsValid; // [R18]
        statusWord[ST_IN_BUSY]  = evt.inBusy; // [R18] [R14]
        statusWord[ST_OUT_BUSY] = evt.outBusy; // [R19] [R14]
        statusWord[ST_WDOG]     = st.wdog; // [R20]
        statusWord[ST_ACYCLIC]  = st.rstActive; // [R20]
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_st           = st;
        next_st.updStrobe = 1'b0;
        next_st.ready     = 1'b1;
        doReset           = 1'b0;

        // Bus write data phase: data is taken one cycle after the address phase
        if (st.ahbWrite) begin
            case (st.ahbAddr)
                OFS_CTRL: begin
                    next_st.userLamp = hwdata[CTRL_USER_LAMP];
                    doReset          = hwdata[CTRL_RESET_CALL];
                end
                OFS_ACTMAP: next_st.actMap = hwdata;
                default: ;
            endcase
        end

        // Address phase; read data is fetched here so it stands in the data phase
        next_st.ahbWrite = 1'b0;
        if (hsel && hready && htrans[1]) begin
            next_st.ahbWrite = hwrite;
            next_st.ahbAddr  = haddr[7:0];
            if (!hwrite) begin
                case (haddr[7:0])
                    OFS_STATUS: next_st.rdata = {16'h0000, statusWord};
                    OFS_CTRL:   next_st.rdata = {30'h0000_0000, st.userLamp, st.rstActive};
                    OFS_FAULT:  next_st.rdata = {st.faultAct, st.faultPersist, 18'h0_0000,
                                                 st.faultCode, 2'h0, st.faultArg};
                    OFS_ACTMAP: next_st.rdata = st.actMap;
                    default:    next_st.rdata = 32'h0000_0000;
                endcase
            end
        end

        // Reset call: start acyclic bus reset, drop errors except those kept to power-up
        if (doReset) begin
            next_st.rstActive = 1'b1; // [R21]
            next_st.rstTimer  = load(BUS_RESET_CYC);
            next_st.cfgChg    = 1'b0;
            next_st.wdog      = 1'b0;
            next_st.lenErr    = 1'b0;
            if (!st.faultPersist) begin
                next_st.faultAct = 1'b0; // [R21] [R12]
            end
        end else if (st.rstActive) begin
            if (st.rstTimer == 32'h0000_0000) begin
                next_st.rstActive = 1'b0;
            end else begin
                next_st.rstTimer = st.rstTimer - 32'h0000_0001;
            end
        end

        // Events come after the clear so a same-cycle event is never lost
        if (evt.cfgChanged) begin
            next_st.cfgChg = 1'b1;
        end
        if (evt.watchdog) begin
            next_st.wdog = 1'b1;
        end
        if (evt.lenMismatch) begin
            next_st.lenErr = 1'b1;
        end
        // First fault is kept so the blink code stays stable; break wins over others
        if (!next_st.faultAct) begin
            if (evt.busBreak) begin
                next_st.faultAct     = 1'b1;
                next_st.faultPersist = 1'b0;
                next_st.faultCode    = CODE_BREAK; // [R9]
                next_st.faultArg     = countActive(st.actMap, evt.breakSlot); // [R9]
            end else if (evt.regFail) begin
                // Modules ahead of the failing one, plus the failing one itself
                next_st.faultAct     = 1'b1;
                next_st.faultPersist = 1'b1; // [R12]
                next_st.faultCode    = CODE_REGCOMM; // [R10]
                next_st.faultArg     = countActive(st.actMap, evt.regSlot - 6'h01) + 6'h01; // [R10]
            end else if (evt.lenMismatch) begin
                next_st.faultAct     = 1'b1;
                next_st.faultPersist = 1'b0;
                next_st.faultCode    = CODE_LENGTH; // [R11]
                next_st.faultArg     = 6'h00; // [R11]
            end
        end

        // Bus update pacing; held off while the acyclic reset runs
        if (next_st.rstActive || st.updTimer == 32'h0000_0000) begin
            next_st.updTimer  = load(UPDATE_CYC); // [R16]
            next_st.updStrobe = ~next_st.rstActive;
        end else begin
            next_st.updTimer = st.updTimer - 32'h0000_0001;
        end

        // Blink sequencer; a cleared fault stops it at once
        if (st.blinkTimer != 32'h0000_0000) begin
            next_st.blinkTimer = st.blinkTimer - 32'h0000_0001;
        end
        if (!st.faultAct) begin
            next_st.blink      = BL_IDLE; // [R4]
            next_st.blinkTimer = 32'h0000_0000;
        end else if (st.blinkTimer == 32'h0000_0000) begin
            case (st.blink)
                BL_IDLE: begin
                    next_st.showCode   = st.faultCode;
                    next_st.showArg    = st.faultArg;
                    next_st.pulseCnt   = LEAD_BLINKS;
                    next_st.blink      = BL_LEAD_ON; // [R6]
                    next_st.blinkTimer = load(FAST_HALF_CYC); // [R5]
                end
                BL_LEAD_ON: begin
                    next_st.blink      = BL_LEAD_OFF;
                    next_st.blinkTimer = load(FAST_HALF_CYC); // [R5]
                end
                BL_LEAD_OFF: begin
                    if (st.pulseCnt == 6'h01) begin
                        next_st.pulseCnt   = {2'h0, st.showCode};
                        next_st.blink      = BL_CODE_ON; // [R6]
                        next_st.blinkTimer = load(SLOW_HALF_CYC); // [R5]
                    end else begin
                        next_st.pulseCnt   = st.pulseCnt - 6'h01;
                        next_st.blink      = BL_LEAD_ON;
                        next_st.blinkTimer = load(FAST_HALF_CYC);
                    end
                end
                BL_CODE_ON: begin
                    next_st.blink      = BL_CODE_OFF;
                    next_st.blinkTimer = load(SLOW_HALF_CYC);
                end
                BL_CODE_OFF: begin
                    if (st.pulseCnt <= 6'h01) begin
                        next_st.blink      = BL_PAUSE; // [R6]
                        next_st.blinkTimer = load(PAUSE_CYC);
                    end else begin
                        next_st.pulseCnt   = st.pulseCnt - 6'h01;
                        next_st.blink      = BL_CODE_ON;
                        next_st.blinkTimer = load(SLOW_HALF_CYC);
                    end
                end
                BL_PAUSE: begin
                    if (st.showArg == 6'h00) begin
                        next_st.blink      = BL_GAP; // [R9] [R11]
                        next_st.blinkTimer = load(GAP_CYC);
                    end else begin
                        next_st.pulseCnt   = st.showArg;
                        next_st.blink      = BL_ARG_ON; // [R6]
                        next_st.blinkTimer = load(SLOW_HALF_CYC);
                    end
                end
                BL_ARG_ON: begin
                    next_st.blink      = BL_ARG_OFF;
                    next_st.blinkTimer = load(SLOW_HALF_CYC);
                end
                BL_ARG_OFF: begin
                    if (st.pulseCnt <= 6'h01) begin
                        next_st.blink      = BL_GAP;
                        next_st.blinkTimer = load(GAP_CYC);
                    end else begin
                        next_st.pulseCnt   = st.pulseCnt - 6'h01;
                        next_st.blink      = BL_ARG_ON;
                        next_st.blinkTimer = load(SLOW_HALF_CYC);
                    end
                end
                BL_GAP:  next_st.blink = BL_IDLE; // [R22]
                default: next_st.blink = BL_IDLE;
            endcase
        end

        // Lamps, registered so every output comes from a flop
        case (evt.rtMode)
            RT_RUN:    next_st.lamps.runtime_status_lamp = RGB_GREEN; // [R1]
            RT_STOP:   next_st.lamps.runtime_status_lamp = RGB_RED; // [R1]
            RT_CONFIG: next_st.lamps.runtime_status_lamp = RGB_BLUE; // [R1]
            default:   next_st.lamps.runtime_status_lamp = RGB_YELLOW; // [R1]
        endcase
        next_st.lamps.sysFault = ~evt.bootDone | evt.bootFault; // [R2]
        next_st.lamps.busRun   = evt.bootDone & ~evt.bootFault & evt.fieldbusRun
                               & ~next_st.faultAct & ~next_st.lenErr
                               & ~next_st.rstActive; // [R3]
        next_st.lamps.busErr   = (next_st.blink == BL_LEAD_ON) ||
                                 (next_st.blink == BL_CODE_ON) ||
                                 (next_st.blink == BL_ARG_ON); // [R4]
        next_st.lamps.user_diag_lamp = st.userLamp;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // State register; power-on reset is the only way to drop a persistent fault
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            st              <= '0; // [R12]
            st.ready        <= 1'b1;
            st.actMap       <= ACTMAP_RST;
            st.blink        <= BL_IDLE;
            st.lamps        <= '0;
            st.lamps.sysFault <= 1'b1; // [R2]
            st.lamps.runtime_status_lamp <= RGB_RED;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops, except hresp, which is tied low
    assign hreadyout      = st.ready;
    assign hresp          = 1'b0;
    assign hrdata         = st.rdata;
    assign lamps          = st.lamps;
    assign busUpdate      = st.updStrobe;
    assign busResetActive = st.rstActive;

endmodule

/* File: tbfbi_indicator_assertions.sv */
// Purpose: Port assertions of the fault blink indicator
// Assumes: Half periods of at least 4 cycles
// Notes:   Blink checks hold for the fast and the slow rate alike
`timescale 1ns/1ps
module tbfbi_chk (
    input wire logic                    ref_clk,
    input wire logic                    srst,
    input wire logic                    hreadyout,
    input wire logic                    hresp,
    input wire tbfbi_pkg::tbfbi_evt_t   evt,
    input wire tbfbi_pkg::tbfbi_lamps_t lamps,
    input wire logic                    busUpdate,
    input wire logic                    busResetActive
);
    import tbfbi_pkg::*;
    ////////////////////////////////////////////////////////////////////////////////
    // Colour expected for each runtime mode
    function automatic logic [2:0] colour(tbfbi_rt_mode_t m);
        case (m)
            RT_RUN:    return RGB_GREEN;
            RT_STOP:   return RGB_RED;
            RT_CONFIG: return RGB_BLUE;
            default:   return RGB_YELLOW;
        endcase
    endfunction
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    // Shortest lit and dark spans of any flash
    sequence s_on4;  lamps.busErr [*4]; endsequence
    sequence s_off4; !lamps.busErr [*4]; endsequence
    property p_ready;    hreadyout && !hresp; endproperty
    property p_colour;   !$past(srst) |-> lamps.runtime_status_lamp == colour($past(evt.rtMode));
    endproperty
    property p_sysFault; !$past(srst) && !$past(evt.bootDone) |-> lamps.sysFault; endproperty
    property p_busRun;   lamps.busRun |-> $past(evt.fieldbusRun) && !lamps.busErr; endproperty
    property p_blinkOn;  $rose(lamps.busErr) |-> s_on4; endproperty
    property p_blinkOff; $fell(lamps.busErr) |-> s_off4; endproperty
    property p_updGap;   busUpdate |=> !busUpdate [*8]; endproperty
    property p_updHold;  busResetActive |-> !busUpdate; endproperty
    a_ready:    assert property (p_ready) else $error("bus not ready or not okay");
    a_colour:   assert property (p_colour) else $error("runtime lamp colour wrong");
    a_sysFault: assert property (p_sysFault) else $error("system lamp dark in boot");
    a_busRun:   assert property (p_busRun) else $error("run lamp lit wrongly");
    a_blinkOn:  assert property (p_blinkOn) else $error("flash too short");
    a_blinkOff: assert property (p_blinkOff) else $error("dark span too short");
    a_updGap:   assert property (p_updGap) else $error("updates too close");
    a_updHold:  assert property (p_updHold) else $error("update in bus reset");
endmodule
bind tbfbi_indicator tbfbi_chk u_chk (
    .ref_clk(ref_clk), .srst(srst), .hreadyout(hreadyout), .hresp(hresp), .evt(evt),
    .lamps(lamps), .busUpdate(busUpdate), .busResetActive(busResetActive));

/* File: tbfbi_term_chain.sv */
// Purpose: Behavioural chain of attached terminal modules
// Assumes: Faults are reported to the indicator at a bus update
// Notes:   Slot lines show the inverse of their last value when unqualified
`timescale 1ns/1ps
module tbfbi_term_chain (
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire logic              busUpdate,
    input wire logic              busResetActive,
    input wire logic [2:0]        kind,
    input wire logic [5:0]        slot,
    output tbfbi_pkg::tbfbi_evt_t chainEvt
);
    import tbfbi_pkg::*;
    logic hit;
    assign hit = busUpdate && !srst;
    // One-cycle reports; slots are physical, passive modules included
    always_ff @(posedge ref_clk) begin
        {chainEvt.rtMode, chainEvt.bootDone, chainEvt.bootFault, chainEvt.fieldbusRun} <= '0;
        chainEvt.busBreak    <= hit && kind == 3'h1;
        chainEvt.regFail     <= hit && kind == 3'h2;
        chainEvt.lenMismatch <= hit && kind == 3'h3;
        chainEvt.cfgChanged  <= hit && kind == 3'h4;
        chainEvt.watchdog    <= hit && kind == 3'h5;
        chainEvt.breakSlot   <= (hit && kind == 3'h1) ? slot : ~chainEvt.breakSlot;
        chainEvt.regSlot     <= (hit && kind == 3'h2) ? slot : ~chainEvt.regSlot;
        chainEvt.inBusy      <= 1'b0;
        chainEvt.outBusy     <= 1'b0;
        // Inputs are stale again after any reset of the chain
        if (srst || busResetActive) chainEvt.inputsValid <= 1'b0;
        else if (busUpdate) chainEvt.inputsValid <= 1'b1;
    end
endmodule

/* File: test_tbfbi_indicator.sv */
// Purpose: Self-checking bench of the fault blink indicator
// Assumes: Shortened periods; zero-wait slave, master still waits on hready
// Notes:   Random maps and slots, fixed seed
`timescale 1ns/1ps
module test_tbfbi_indicator;
    import tbfbi_pkg::*;
    localparam int F = 4, S = 8, P = 16, G = 16;
    logic ref_clk = 0, srst = 1, hsel = 0, hwrite = 0, bootDone = 0, fieldbusRun = 1;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r, am, e;
    logic [1:0] htrans = 0;
    logic [2:0] kind = 0;
    logic [5:0] slot = 0, arg;
    logic hreadyout, hresp, busUpdate, busResetActive, prev;
    tbfbi_rt_mode_t rtMode = RT_RUN;
    tbfbi_lamps_t lamps;
    tbfbi_evt_t chainEvt, evt;
    int seed = 55612, n_fail = 0, check_count = 0, c, code, k;
    assign evt = {rtMode, bootDone, 1'b0, fieldbusRun, chainEvt[19:0]};
    always #10 ref_clk = ~ref_clk;
    // Random runtime mode, every colour
    always @(posedge ref_clk) rtMode <= tbfbi_rt_mode_t'(2'($random(seed)));
    tbfbi_indicator #(.FAST_HALF_CYC(F), .SLOW_HALF_CYC(S), .PAUSE_CYC(P), .GAP_CYC(G),
        .UPDATE_CYC(20), .BUS_RESET_CYC(10)) u_dut (.ref_clk(ref_clk), .srst(srst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .evt(evt), .lamps(lamps), .busUpdate(busUpdate),
        .busResetActive(busResetActive));
    tbfbi_term_chain u_chain (.ref_clk(ref_clk), .srst(srst), .busUpdate(busUpdate),
        .busResetActive(busResetActive), .kind(kind), .slot(slot), .chainEvt(chainEvt));
    ////////////////////////////////////////////////////////////////////////////////
    // Active modules among the first n physical slots
    function automatic logic [5:0] pos(logic [31:0] m, int n);
        int t = 0;
        for (int i = 0; i < n; i++) t += m[i];
        return t[5:0];
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Single word transfer; waits on hready in both phases
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        hsel <= 1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w;
        n = 0;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
        hsel <= 0; htrans <= 2'h0; hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 100);
        r = hrdata;
    endtask
    // Fault reported at the next update
    task automatic inject(input logic [2:0] kd, input logic [5:0] s);
        int n = 0;
        kind <= kd; slot <= s;
        do @(posedge ref_clk); while (busUpdate !== 1'b1 && ++n < 40);
        kind <= 0;
        repeat (2) @(posedge ref_clk);
    endtask
    task automatic rst_pulse;
        srst <= 1;
        repeat (12) @(posedge ref_clk);
        srst <= 0;
    endtask
    task summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 0; bootDone <= 1;
        ahb(0, OFS_STATUS, 0); chk(r, 32'h0000_0100);
        ahb(0, OFS_ACTMAP, 0); chk(r, ACTMAP_RST);
        repeat (25) @(posedge ref_clk);
        ahb(0, OFS_STATUS, 0); chk(r, 32'h0000_0000);
        chk(lamps.busRun, 1); chk(lamps.sysFault, 0);
        for (k = 1; k <= 3; k++) begin
            rst_pulse();
            am = $random(seed);
            ahb(1, OFS_ACTMAP, am);
            slot = 6'({$random(seed)} % 20) + 6'(k == 2);
            code = (k == 1) ? 4 : (k == 2) ? 5 : 7;
            arg = (k == 1) ? pos(am, slot) : (k == 2) ? pos(am, slot - 1) + 6'h1 : 6'h0;
            inject(3'(k), slot);
            for (int n = 0; n < 40 && lamps.busErr !== 1'b1; n++) @(posedge ref_clk);
            c = 1;
            prev = 1'b1;
            repeat (16 * F + (code + arg) * 2 * S + P + G - 2) begin
                @(posedge ref_clk);
                if (lamps.busErr === 1'b1 && prev === 1'b0) c++;
                prev = lamps.busErr;
            end
            chk(c, 8 + code + arg);
            for (c = 0; c < 40 && lamps.busErr !== 1'b1; c++) @(posedge ref_clk);
            chk(lamps.busErr, 1);
            e = {1'b1, k == 2, 18'h0, 4'(code), 2'h0, arg};
            ahb(0, OFS_FAULT, 0); chk(r, e);
            ahb(0, OFS_STATUS, 0); chk(r & 32'h0000_0005, {k == 3, 2'h1});
            chk(lamps.busRun, 0);
            ahb(1, OFS_CTRL, 32'h0000_0001);
            ahb(0, OFS_STATUS, 0); chk(r & 32'h0000_8000, 32'h0000_8000);
            for (c = 0; c < 60 && busResetActive !== 1'b0; c++) @(posedge ref_clk);
            ahb(0, OFS_FAULT, 0); chk(r, (k == 2) ? e : e & 32'h7FFF_FFFF);
        end
        rst_pulse();
        repeat (30) @(posedge ref_clk);
        chk(lamps.busErr, 0);
        inject(3'h4, 0);
        inject(3'h5, 0);
        ahb(0, OFS_STATUS, 0); chk(r & 32'h0000_0803, 32'h0000_0802);
        ahb(0, 8'h10, 0); chk(r, 0);
        ahb(1, OFS_CTRL, 32'h0000_0002);
        repeat (2) @(posedge ref_clk);
        chk(lamps.user_diag_lamp, 1);
        summarize();
    end
    // Watchdog against a hung wait
    initial begin
        repeat (30000) @(posedge ref_clk);
        n_fail++;
        summarize();
    end
endmodule
